//--- clock_mode_and_tick_generator_test.sv
// Self-checking bench for strap decoding and tick placement.
// Assumes the board model drives input_clock with a 40-cycle period.
`timescale 1ns/10ps
module clock_mode_and_tick_generator_test;
    import cmt_pkg::*;
    typedef struct packed {logic [6:0] code; logic [2:0] comms; logic [3:0] core; logic valid;} cmt_row_t;
    logic clk, reset, clk_en, run, input_clock, msh, tk_rise, tk_second, tk_fall, tk_fourth, launch, valid, ready;
    logic [6:0] code;
    logic [5:0] msl;
    logic [2:0] comms;
    logic [3:0] core;
    logic [1:0] bus;
    cmt_ratio_t ratio;
    int mismatches = 0;
    int n_tests = 0;
    cmt_row_t rows [9] = '{{7'h0d, 3'h3, 4'h4, 1'b1}, {7'h11, 3'h3, 4'h8, 1'b1}, {7'h12, 3'h4, 4'h4, 1'b1},
        {7'h17, 3'h5, 4'h4, 1'b1}, {7'h1e, 3'h6, 4'h6, 1'b1}, {7'h20, 3'h6, 4'h8, 1'b1},
        {7'h0c, 3'h0, 4'h0, 1'b0}, {7'h21, 3'h0, 4'h0, 1'b0}, {7'h7f, 3'h0, 4'h0, 1'b0}};

    cmt_board_model cmt_board_model_i (.clk(clk), .run(run), .half_period(8'h14), .strap_code(code),
        .input_clock(input_clock), .mode_strap_high(msh), .mode_strap_low(msl));
    cmt_tick_gen cmt_tick_gen_i (.clk(clk), .reset(reset), .clk_en(clk_en), .input_clock(input_clock),
        .mode_strap_high(msh), .mode_strap_low(msl), .ratio_class(ratio), .tick_rise(tk_rise),
        .tick_second(tk_second), .tick_fall(tk_fall), .tick_fourth(tk_fourth), .launch_rise(launch),
        .comms_processor_mult(comms),
        .core_mult(core), .bus_mult(bus), .mode_valid(valid), .factors_ready(ready));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic stop_test;
        $display("Checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step

    task automatic do_reset(input logic [6:0] c, input cmt_ratio_t r);
        code <= c;
        ratio <= r;
        reset <= 1'b1;
        step(2);
        check("ready_in_reset", {7'h00, ready}, 8'h00);
        reset <= 1'b0;
        step(4);
    endtask : do_reset

    // Offsets of each tick from the rising-edge tick, in clk cycles
    task automatic ticks(input cmt_ratio_t r, input logic [7:0] e2, input logic [7:0] e4);
        int i;
        logic [7:0] p1, p2, p3, p4;
        {p1, p2, p3, p4} = 32'h0;
        do_reset(7'h0d, r);
        step(100);
        for (i = 0; i < 60 && tk_rise !== 1'b1; i++)
            step(1);
        if (i == 60)
        begin
            mismatches++;
            stop_test();
        end
        check("launch", {7'h00, launch}, 8'h01);
        for (i = 1; i <= 40; i++)
        begin
            step(1);
            if (tk_rise === 1'b1) p1 = i[7:0];
            if (tk_second === 1'b1) p2 = i[7:0];
            if (tk_fall === 1'b1) p3 = i[7:0];
            if (tk_fourth === 1'b1) p4 = i[7:0];
        end
        check("rise", p1, 8'h28);
        check("second", p2, e2);
        check("fall", p3, 8'h14);
        check("fourth", p4, e4);
        $display("Test ticks ratio %0d done", r);
    endtask : ticks

    initial
    begin
        reset = 1'b1;
        clk_en = 1'b1;
        run = 1'b0;
        code = 7'h0d;
        ratio = RATIO_INT;
        step(1);
        run <= 1'b1;
        foreach (rows[k])
        begin
            do_reset(rows[k].code, RATIO_INT);
            check("comms", {5'h00, comms}, {5'h00, rows[k].comms});
            check("core", {4'h0, core}, {4'h0, rows[k].core});
            check("valid", {7'h00, valid}, {7'h00, rows[k].valid});
            check("bus", {6'h00, bus}, 8'h01);
            check("ready", {7'h00, ready}, 8'h01);
            $display("Test row %0d done", k);
        end
        do_reset(7'h12, RATIO_INT);
        code <= 7'h20;
        step(6);
        check("held_core", {4'h0, core}, 8'h04);
        check("held_comms", {5'h00, comms}, 8'h04);
        $display("Test strap hold done");
        ticks(RATIO_INT, 8'h0a, 8'h1e);
        ticks(RATIO_2P5, 8'h0c, 8'h20);
        ticks(RATIO_3P5, 8'h0b, 8'h1f);
        reset <= 1'b1;
        step(2);
        clk_en <= 1'b0;
        reset <= 1'b0;
        step(6);
        check("frozen_ready", {7'h00, ready}, 8'h00);
        check("frozen_core", {4'h0, core}, 8'h00);
        clk_en <= 1'b1;
        step(3);
        check("thawed_ready", {7'h00, ready}, 8'h01);
        check("thawed_core", {4'h0, core}, 8'h04);
        $display("Test enable freeze done");
        stop_test();
    end
endmodule : clock_mode_and_tick_generator_test

//--- cmt_board_model.sv
// Board model: input clock source and mode strapping seen by the tick generator.
// Assumes clk is the fast sampling clock and half_period is at least 2.
`timescale 1ns/10ps
module cmt_board_model
(
    input wire logic clk,
    input wire logic run,
    input wire logic [7:0] half_period,
    input wire logic [6:0] strap_code,
    output logic input_clock,
    output logic mode_strap_high,
    output logic [5:0] mode_strap_low
);
    logic [7:0] cnt_q;

    // Strap pins follow the board setting
    assign mode_strap_high = strap_code[6];
    assign mode_strap_low = strap_code[5:0];

    // Free-running input clock, launched just after a clk edge; held low while run is low
    always_ff @(posedge clk)
    begin
        if (!run)
        begin
            cnt_q <= 8'h00;
            input_clock <= 1'b0;
        end
        else if (cnt_q == half_period - 8'h01)
        begin
            cnt_q <= 8'h00;
            input_clock <= ~input_clock;
        end
        else
        begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule : cmt_board_model

//--- cmt_mode_decode.sv
// Combinational decoder of the seven-bit clock-mode strap.
// Assumes the strap value is already held stable by the caller.
`timescale 1ns/10ps
module cmt_mode_decode
    import cmt_pkg::*;
(
    input wire logic [cmt_pkg::STRAP_W-1:0] code,
    output logic [cmt_pkg::COMMS_W-1:0] comms_mult,
    output logic [cmt_pkg::CORE_W-1:0] core_mult,
    output logic valid
);
    logic [4:0] idx;
    logic [4:0] grp;
    logic [4:0] step;

    always_comb
    begin
        idx = 5'(code - STRAP_FIRST);
        grp = 5'(idx / CORE_STEPS);
        step = 5'(idx % CORE_STEPS);
        valid = (code >= STRAP_FIRST) && (code <= STRAP_LAST);
        if (valid)
        begin
            comms_mult = COMMS_BASE + grp[2:0];
            core_mult = CORE_BASE + step[3:0];
        end
        else
        begin
            comms_mult = 3'h0;
            core_mult = 4'h0;
        end
    end
endmodule : cmt_mode_decode

//--- cmt_pkg.sv
// Constants for the clock-mode decoder and the memory-controller tick generator.
// Assumes a single fast sampling clock that is much faster than the input clock.
package cmt_pkg;
    localparam int STRAP_W = 7;
    localparam int COMMS_W = 3;
    localparam int CORE_W = 4;
    localparam int CNT_W = 8;
    localparam int PROD_W = 12;
    localparam int FRAC_W = 4;

    // Valid strap window and its layout
    localparam logic [6:0] STRAP_FIRST = 7'h0d;
    localparam logic [6:0] STRAP_LAST = 7'h20;
    localparam logic [6:0] STRAP_RESERVED = 7'h21;
    localparam logic [4:0] CORE_STEPS = 5'h05;
    localparam logic [2:0] COMMS_BASE = 3'h3;
    localparam logic [3:0] CORE_BASE = 4'h4;
    localparam logic [1:0] BUS_MULT = 2'h1;

    // Tick fractions per ratio class: second tick num, fourth tick num, denominator
    localparam logic [3:0] INT_SECOND_NUM = 4'h1;
    localparam logic [3:0] INT_FOURTH_NUM = 4'h3;
    localparam logic [3:0] INT_DEN = 4'h4;
    localparam logic [3:0] H25_SECOND_NUM = 4'h3;
    localparam logic [3:0] H25_FOURTH_NUM = 4'h8;
    localparam logic [3:0] H25_DEN = 4'ha;
    localparam logic [3:0] H35_SECOND_NUM = 4'h4;
    localparam logic [3:0] H35_FOURTH_NUM = 4'hb;
    localparam logic [3:0] H35_DEN = 4'he;

    typedef enum logic [1:0]
    {
        RATIO_INT = 2'h0,
        RATIO_2P5 = 2'h1,
        RATIO_3P5 = 2'h2
    } cmt_ratio_t;

    // Gray sequence along reset -> capture -> run
    typedef enum logic [1:0]
    {
        ST_HOLD = 2'h0,
        ST_CAPTURE = 2'h1,
        ST_RUN = 2'h3
    } cmt_state_t;
endpackage : cmt_pkg

//--- cmt_tick_gen.sv
// Clock-mode strap capture and four-tick generator for the memory controller.
// Assumes clk is a fast internal clock and input_clock is a synchronous sampled level.
`timescale 1ns/10ps
module cmt_tick_gen
    import cmt_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic input_clock,
    input wire logic mode_strap_high,
    input wire logic [5:0] mode_strap_low,
    input wire cmt_pkg::cmt_ratio_t ratio_class,
    output logic tick_rise,
    output logic tick_second,
    output logic tick_fall,
    output logic tick_fourth,
    output logic launch_rise,
    output logic [cmt_pkg::COMMS_W-1:0] comms_processor_mult,
    output logic [cmt_pkg::CORE_W-1:0] core_mult,
    output logic [1:0] bus_mult,
    output logic mode_valid,
    output logic factors_ready
);
    import cmt_pkg::*;

    cmt_state_t state_q;
    logic [STRAP_W-1:0] strap_q;
    cmt_ratio_t ratio_q;
    logic in_q;
    logic primed_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] period_q;
    logic rise;
    logic fall;
    logic [3:0] num2;
    logic [3:0] num4;
    logic [3:0] den;
    logic [PROD_W-1:0] pos2;
    logic [PROD_W-1:0] pos4;
    logic [COMMS_W-1:0] dec_comms;
    logic [CORE_W-1:0] dec_core;
    logic dec_valid;

    // Strap capture: taken in the first enabled cycle after reset release
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= ST_HOLD;
        end
        else if (clk_en)
        begin
            case (state_q)
                ST_HOLD: state_q <= ST_CAPTURE;
                ST_CAPTURE: state_q <= ST_RUN;
                ST_RUN: state_q <= ST_RUN;
                default: state_q <= ST_HOLD;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            strap_q <= 7'h00;
            ratio_q <= RATIO_INT;
        end
        else if (clk_en && state_q == ST_HOLD)
        begin
            strap_q <= {mode_strap_high, mode_strap_low};
            ratio_q <= ratio_class;
        end
    end

    cmt_mode_decode cmt_mode_decode_i
    (
        .code(strap_q),
        .comms_mult(dec_comms),
        .core_mult(dec_core),
        .valid(dec_valid)
    );

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            comms_processor_mult <= 3'h0;
            core_mult <= 4'h0;
            bus_mult <= 2'h0;
            mode_valid <= 1'b0;
            factors_ready <= 1'b0;
        end
        else if (clk_en && state_q == ST_CAPTURE)
        begin
            comms_processor_mult <= dec_comms;
            core_mult <= dec_core;
            bus_mult <= BUS_MULT;
            mode_valid <= dec_valid;
            factors_ready <= 1'b1;
        end
    end

    // Edge detection on the sampled input clock; no edge until one level is seen after reset
    assign rise = primed_q && input_clock && !in_q;
    assign fall = primed_q && !input_clock && in_q;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            in_q <= 1'b0;
            primed_q <= 1'b0;
            cnt_q <= 8'h00;
            period_q <= 8'h00;
        end
        else if (clk_en)
        begin
            in_q <= input_clock;
            primed_q <= 1'b1;
            if (rise)
            begin
                period_q <= cnt_q;
                cnt_q <= 8'h01;
            end
            else if (cnt_q != 8'hff)
            begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    always_comb
    begin
        case (ratio_q)
            RATIO_2P5:
            begin
                num2 = H25_SECOND_NUM;
                num4 = H25_FOURTH_NUM;
                den = H25_DEN;
            end
            RATIO_3P5:
            begin
                num2 = H35_SECOND_NUM;
                num4 = H35_FOURTH_NUM;
                den = H35_DEN;
            end
            default:
            begin
                num2 = INT_SECOND_NUM;
                num4 = INT_FOURTH_NUM;
                den = INT_DEN;
            end
        endcase
        pos2 = PROD_W'((PROD_W'(period_q) * PROD_W'(num2)) / PROD_W'(den));
        pos4 = PROD_W'((PROD_W'(period_q) * PROD_W'(num4)) / PROD_W'(den));
    end

    // Ticks are one-cycle pulses; no period known yet means no mid ticks
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tick_rise <= 1'b0;
            tick_second <= 1'b0;
            tick_fall <= 1'b0;
            tick_fourth <= 1'b0;
            launch_rise <= 1'b0;
        end
        else if (clk_en)
        begin
            tick_rise <= rise;
            launch_rise <= rise;
            tick_fall <= fall;
            tick_second <= !rise && pos2 != 12'h000 && {4'h0, cnt_q} == pos2;
            tick_fourth <= !rise && pos4 != 12'h000 && {4'h0, cnt_q} == pos4;
        end
    end

    rise_tick_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && primed_q && input_clock && !in_q) |=> tick_rise && launch_rise)
        else $error("rising tick missing");

    fall_tick_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && primed_q && !input_clock && in_q) |=> tick_fall && !tick_rise)
        else $error("falling tick missing");

    launch_match_a: assert property (@(posedge clk) disable iff (reset)
        launch_rise == tick_rise)
        else $error("launch strobe off the rising tick");

    second_apart_a: assert property (@(posedge clk) disable iff (reset)
        tick_second |-> !tick_rise && !tick_fourth)
        else $error("second tick collides");

    int_quarter_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && ratio_q == RATIO_INT && period_q == 8'h28 && cnt_q == 8'h0a && !rise) |=> tick_second)
        else $error("quarter tick misplaced");

    half_ratio_a: assert property (@(posedge clk) disable iff (reset)
        (clk_en && ratio_q == RATIO_2P5 && period_q == 8'h28 && cnt_q == 8'h20 && !rise) |=> tick_fourth)
        else $error("2.5 ratio fourth tick misplaced");

    decode_range_a: assert property (@(posedge clk) disable iff (reset)
        mode_valid |-> comms_processor_mult inside {[3:6]} && core_mult inside {[4:8]})
        else $error("decoded factor out of range");

    reserved_code_a: assert property (@(posedge clk) disable iff (reset)
        (factors_ready && strap_q >= STRAP_RESERVED) |-> !mode_valid)
        else $error("reserved code accepted");

    bus_unity_a: assert property (@(posedge clk) disable iff (reset)
        factors_ready |-> bus_mult == 2'h1)
        else $error("bus factor not one");

    factors_hold_a: assert property (@(posedge clk) disable iff (reset)
        factors_ready && $past(factors_ready) |-> $stable(core_mult) && $stable(comms_processor_mult))
        else $error("factors changed after capture");

    enable_freeze_a: assert property (@(posedge clk) disable iff (reset)
        !clk_en |=> $stable(factors_ready) && $stable(core_mult) && $stable(tick_rise))
        else $error("state moved while clock enable low");
endmodule : cmt_tick_gen
